// ### sea_group.sv
// One status group: filters, sticky event register, enable mask, summary
// Assumes cond_in already synchronised and zero in unused positions
`timescale 1ns/1ps
`default_nettype none
`include "sea_map.svh"
module sea_group (
	// Clock and reset
	input wire logic clock_in,
	input wire logic rst_in,
	// Live condition and controls
	input wire logic [15:0] cond_in,
	input wire logic preset_in,
	input wire logic preset_enable_one_in,
	input wire logic event_read_in,
	input wire logic wr_enable_in,
	input wire logic wr_rise_in,
	input wire logic wr_fall_in,
	input wire logic [15:0] wdata_in,
	// State seen by the host
	output logic [15:0] event_out,
	output logic [15:0] enable_out,
	output logic [15:0] rise_out,
	output logic [15:0] fall_out,
	output logic summary_out
);
	logic [15:0] cond_prev_ff;
	logic [15:0] event_ff;
	logic [15:0] enable_ff;
	logic [15:0] rise_ff;
	logic [15:0] fall_ff;
	wire [15:0] rise_hit;
	wire [15:0] fall_hit;
	wire [15:0] nxt_event;
	wire [15:0] preset_enable;

	// Transition detection through the edge filters
	assign rise_hit = cond_in & ~cond_prev_ff & rise_ff;
	assign fall_hit = ~cond_in & cond_prev_ff & fall_ff;
	// Read clears, new edges set after the clear
	assign nxt_event = (event_read_in ? `SEA_ALL_ZERO : event_ff) | rise_hit | fall_hit;
	assign preset_enable = preset_enable_one_in ? `SEA_ALL_ONE : `SEA_ALL_ZERO;
	assign event_out = event_ff;
	assign enable_out = enable_ff;
	assign rise_out = rise_ff;
	assign fall_out = fall_ff;
	// Summary of enabled latched events
	assign summary_out = |(event_ff & enable_ff);

	// Previous condition and sticky events
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			cond_prev_ff <= `SEA_ALL_ZERO;
			event_ff <= `SEA_ALL_ZERO;
		end else begin
			cond_prev_ff <= cond_in;
			event_ff <= nxt_event;
		end
	end

	// Mask and filters, preset wins over a write
	always_ff @(posedge clock_in) begin
		if (rst_in || preset_in) begin
			enable_ff <= preset_enable;
			rise_ff <= `SEA_ALL_ONE;
			fall_ff <= `SEA_ALL_ZERO;
		end else begin
			if (wr_enable_in) enable_ff <= wdata_in;
			if (wr_rise_in) rise_ff <= wdata_in;
			if (wr_fall_in) fall_ff <= wdata_in;
		end
	end

	// Captured edge shows in the event register next cycle
	AST_EDGE_LATCH: assert property (@(posedge clock_in) disable iff (rst_in)
		(|(rise_hit | fall_hit)) |=> ((event_ff & $past(rise_hit | fall_hit))
		== $past(rise_hit | fall_hit))) else $error("edge not latched");
	// Event bit never appears without a filtered edge
	AST_NO_SPURIOUS: assert property (@(posedge clock_in) disable iff (rst_in)
		((event_ff & ~$past(event_ff)) & ~$past(rise_hit | fall_hit)) == 16'h0000
		or $past(rst_in)) else $error("event set without edge");
endmodule : sea_group
`default_nettype wire

// ### sea_host_model.sv
// Host side model: issues register reads and writes on the command port
// Assumes the block answers a read with rvalid within three cycles
`timescale 1ns/1ps
`default_nettype none
module sea_host_model (
	// Clock
	input wire logic clock_in,
	// Read answer from the block
	input wire logic rvalid_in,
	input wire logic [15:0] rdata_in,
	// Command to the block
	output var sea_pkg::sea_cmd_t cmd_out
);
	import sea_pkg::*;
	// Idle command at time zero
	initial begin
		cmd_out = '0;
	end
	// One write, changed at falling edges only
	task write_reg(input logic [3:0] sel, input logic [15:0] val);
		@(negedge clock_in);
		cmd_out.wr = 1'b1;
		cmd_out.sel = sel;
		cmd_out.data = val;
		@(posedge clock_in);
		@(negedge clock_in);
		cmd_out.wr = 1'b0;
		cmd_out.data = ~val; // Released bus shows no stale value
	endtask : write_reg
	// One read, answer taken on the rvalid pulse
	task read_reg(input logic [3:0] sel, output logic [15:0] val);
		int n;
		val = 'x;
		@(negedge clock_in);
		cmd_out.rd = 1'b1;
		cmd_out.sel = sel;
		@(posedge clock_in);
		@(negedge clock_in);
		cmd_out.rd = 1'b0;
		cmd_out.data = ~cmd_out.data;
		for (n = 0; n < 3; n++) begin
			if (rvalid_in === 1'b1) begin
				val = rdata_in;
				break;
			end
			@(negedge clock_in);
		end
	endtask : read_reg
	// Back to back reads, answers merged
	task read_burst(input logic [3:0] sel, input int cycles, output logic [15:0] acc);
		acc = '0;
		@(negedge clock_in);
		cmd_out.rd = 1'b1;
		cmd_out.sel = sel;
		repeat (cycles) begin
			@(posedge clock_in);
			@(negedge clock_in);
			if (rvalid_in === 1'b1) acc |= rdata_in;
		end
		cmd_out.rd = 1'b0;
		repeat (2) begin
			@(negedge clock_in);
			if (rvalid_in === 1'b1) acc |= rdata_in;
		end
	endtask : read_burst
endmodule : sea_host_model
`default_nettype wire

// ### sea_map.svh
// Register selectors, field positions and preset values of the status block
// Assumes the includer is a module or package scope that may see macros
`ifndef SEA_MAP_SVH
`define SEA_MAP_SVH
// Register selector codes on the command port
`define SEA_SEL_OP_COND 4'h0
`define SEA_SEL_OP_EVENT 4'h1
`define SEA_SEL_OP_ENABLE 4'h2
`define SEA_SEL_OP_RISE 4'h3
`define SEA_SEL_OP_FALL 4'h4
`define SEA_SEL_QU_COND 4'h5
`define SEA_SEL_QU_EVENT 4'h6
`define SEA_SEL_QU_ENABLE 4'h7
`define SEA_SEL_QU_RISE 4'h8
`define SEA_SEL_QU_FALL 4'h9
`define SEA_SEL_DEV_ENABLE 4'ha
`define SEA_SEL_CAL_ENABLE 4'hb
`define SEA_SEL_DEV_RISE 4'hc
`define SEA_SEL_DEV_FALL 4'hd
`define SEA_SEL_CAL_RISE 4'he
`define SEA_SEL_CAL_FALL 4'hf
// Operation condition bits in use
`define SEA_OP_USED_MASK 16'h0f37
// Operation measuring bit position
`define SEA_OP_MEAS_BIT 4
// Questionable condition bit positions
`define SEA_QU_VOLT_BIT 3
`define SEA_QU_ZERO_BIT 8
// Reset and preset values
`define SEA_ALL_ZERO 16'h0000
`define SEA_ALL_ONE 16'hffff
`endif

// ### sea_pkg.sv
// Types shared by the status event aggregator files
// Assumes sea_map.svh is reachable on the include path
`default_nettype none
package sea_pkg;
	// One host command on the register port
	typedef struct packed {
		logic wr;
		logic rd;
		logic [3:0] sel;
		logic [15:0] data;
	} sea_cmd_t;
	// Live instrument state that feeds the operation group
	typedef struct packed {
		logic zeroing;
		logic settling;
		logic ranging;
		logic measuring;
		logic triggering;
		logic [1:0] alarm;
		logic [1:0] alarm_latch;
	} sea_op_state_t;
endpackage : sea_pkg
`default_nettype wire

// ### sea_status_top.sv
// Status event aggregator: operation and questionable groups with preset
// Assumes a command decoder presents one register access per cycle
// Functional notes
// - Operation event read returns contents and clears all bits; code keeps edges seen in the read cycle
// - Operation events latch filtered condition edges, sticky
// - Falling filter bit set and condition one-to-zero sets event
// - Rising filter bit set and condition zero-to-one sets event
// - All status registers are sixteen bits, reads give full value
// - Preset clears operation and questionable enable masks
// - Preset sets device and calibration enable masks to all ones
// - Preset sets all rising filters, clears all falling filters
// - Questionable bit 3 high when voltage reading may be invalid
// - Questionable bit 8 high when probe needs zeroing
// - Questionable condition follows live state, no latching
// - Questionable summary is OR of events masked by enable
// - Questionable summary is a status byte bit
// - Questionable events latch filtered condition edges, sticky
// - Questionable event read returns contents and clears all bits; code keeps edges seen in the read cycle
// - Operation summary is OR of events masked by enable
// - Operation condition bit layout for zeroing through alarm latches
// - Questionable group has its own rising and falling filters
`timescale 1ns/1ps
`default_nettype none
`include "sea_map.svh"
module sea_status_top (
	// Clock and reset
	input wire logic clock_in,
	input wire logic rst_in,
	// Host command port
	input wire sea_pkg::sea_cmd_t cmd_in,
	input wire logic preset_in,
	output logic [15:0] rdata_out,
	output logic rvalid_out,
	// Instrument state pins
	input wire sea_pkg::sea_op_state_t op_state_in,
	input wire logic volt_invalid_in,
	input wire logic zero_needed_in,
	input wire logic [15:0] dev_cond_in,
	input wire logic [15:0] cal_cond_in,
	// Status byte summary bits
	output logic op_summary_out,
	output logic qu_summary_out,
	output logic dev_summary_out,
	output logic cal_summary_out
);
	import sea_pkg::*;

	logic [10:0] sync1_ff;
	logic [10:0] sync2_ff;
	logic [10:0] sync3_ff;
	logic [10:0] stable_ff;
	logic [15:0] rdata_ff;
	logic rvalid_ff;
	logic [15:0] dev_s1_ff;
	logic [15:0] dev_s2_ff;
	logic [15:0] dev_s3_ff;
	logic [15:0] dev_st_ff;
	logic [15:0] cal_s1_ff;
	logic [15:0] cal_s2_ff;
	logic [15:0] cal_s3_ff;
	logic [15:0] cal_st_ff;
	wire [10:0] raw_pins;
	wire [15:0] op_cond;
	wire [15:0] qu_cond;
	wire [15:0] op_event, op_enable, op_rise, op_fall;
	wire [15:0] qu_event, qu_enable, qu_rise, qu_fall;
	wire [15:0] dev_event, dev_enable, dev_rise, dev_fall;
	wire [15:0] cal_event, cal_enable, cal_rise, cal_fall;
	wire [15:0] nxt_rdata;

	// Write strobe for one selector
	function automatic logic wr_hit(input sea_cmd_t c, input logic [3:0] s);
		wr_hit = c.wr && (c.sel == s);
	endfunction : wr_hit

	// Pins gathered for synchronising
	assign raw_pins = {zero_needed_in, volt_invalid_in, op_state_in.alarm_latch,
		op_state_in.alarm, op_state_in.triggering, op_state_in.measuring,
		op_state_in.ranging, op_state_in.settling, op_state_in.zeroing};

	// Three-stage synchronisers, change accepted when stages two and three agree
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			sync1_ff <= 11'h000;
			sync2_ff <= 11'h000;
			sync3_ff <= 11'h000;
			stable_ff <= 11'h000;
		end else begin
			sync1_ff <= raw_pins;
			sync2_ff <= sync1_ff;
			sync3_ff <= sync2_ff;
			stable_ff <= (sync2_ff & sync3_ff) | (stable_ff & (sync2_ff | sync3_ff));
		end
	end

	// Device and calibration conditions through the same filter
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			dev_s1_ff <= `SEA_ALL_ZERO;
			dev_s2_ff <= `SEA_ALL_ZERO;
			dev_s3_ff <= `SEA_ALL_ZERO;
			dev_st_ff <= `SEA_ALL_ZERO;
			cal_s1_ff <= `SEA_ALL_ZERO;
			cal_s2_ff <= `SEA_ALL_ZERO;
			cal_s3_ff <= `SEA_ALL_ZERO;
			cal_st_ff <= `SEA_ALL_ZERO;
		end else begin
			dev_s1_ff <= dev_cond_in;
			dev_s2_ff <= dev_s1_ff;
			dev_s3_ff <= dev_s2_ff;
			dev_st_ff <= (dev_s2_ff & dev_s3_ff) | (dev_st_ff & (dev_s2_ff | dev_s3_ff));
			cal_s1_ff <= cal_cond_in;
			cal_s2_ff <= cal_s1_ff;
			cal_s3_ff <= cal_s2_ff;
			cal_st_ff <= (cal_s2_ff & cal_s3_ff) | (cal_st_ff & (cal_s2_ff | cal_s3_ff));
		end
	end

	// Operation condition layout, unused bits tied low
	assign op_cond = {4'h0, stable_ff[8:7], stable_ff[6:5], 2'h0, stable_ff[4:3], 1'b0,
		stable_ff[2:0]} & `SEA_OP_USED_MASK;
	// Questionable condition is combinational from live state
	assign qu_cond = (16'h0001 << `SEA_QU_VOLT_BIT) & {16{stable_ff[9]}}
		| (16'h0001 << `SEA_QU_ZERO_BIT) & {16{stable_ff[10]}};

	// Operation group, enable mask cleared at preset
	sea_group u_op (
		.clock_in(clock_in),
		.rst_in(rst_in),
		.cond_in(op_cond),
		.preset_in(preset_in),
		.preset_enable_one_in(1'b0),
		.event_read_in(cmd_in.rd && (cmd_in.sel == `SEA_SEL_OP_EVENT)),
		.wr_enable_in(wr_hit(cmd_in, `SEA_SEL_OP_ENABLE)),
		.wr_rise_in(wr_hit(cmd_in, `SEA_SEL_OP_RISE)),
		.wr_fall_in(wr_hit(cmd_in, `SEA_SEL_OP_FALL)),
		.wdata_in(cmd_in.data),
		.event_out(op_event),
		.enable_out(op_enable),
		.rise_out(op_rise),
		.fall_out(op_fall),
		.summary_out(op_summary_out)
	);

	// Questionable group with its own filters
	sea_group u_qu (
		.clock_in(clock_in),
		.rst_in(rst_in),
		.cond_in(qu_cond),
		.preset_in(preset_in),
		.preset_enable_one_in(1'b0),
		.event_read_in(cmd_in.rd && (cmd_in.sel == `SEA_SEL_QU_EVENT)),
		.wr_enable_in(wr_hit(cmd_in, `SEA_SEL_QU_ENABLE)),
		.wr_rise_in(wr_hit(cmd_in, `SEA_SEL_QU_RISE)),
		.wr_fall_in(wr_hit(cmd_in, `SEA_SEL_QU_FALL)),
		.wdata_in(cmd_in.data),
		.event_out(qu_event),
		.enable_out(qu_enable),
		.rise_out(qu_rise),
		.fall_out(qu_fall),
		.summary_out(qu_summary_out)
	);

	// Device group, enables all ones at preset
	sea_group u_dev (
		.clock_in(clock_in),
		.rst_in(rst_in),
		.cond_in(dev_st_ff),
		.preset_in(preset_in),
		.preset_enable_one_in(1'b1),
		.event_read_in(1'b0),
		.wr_enable_in(wr_hit(cmd_in, `SEA_SEL_DEV_ENABLE)),
		.wr_rise_in(wr_hit(cmd_in, `SEA_SEL_DEV_RISE)),
		.wr_fall_in(wr_hit(cmd_in, `SEA_SEL_DEV_FALL)),
		.wdata_in(cmd_in.data),
		.event_out(dev_event),
		.enable_out(dev_enable),
		.rise_out(dev_rise),
		.fall_out(dev_fall),
		.summary_out(dev_summary_out)
	);

	// Calibration group, enables all ones at preset
	sea_group u_cal (
		.clock_in(clock_in),
		.rst_in(rst_in),
		.cond_in(cal_st_ff),
		.preset_in(preset_in),
		.preset_enable_one_in(1'b1),
		.event_read_in(1'b0),
		.wr_enable_in(wr_hit(cmd_in, `SEA_SEL_CAL_ENABLE)),
		.wr_rise_in(wr_hit(cmd_in, `SEA_SEL_CAL_RISE)),
		.wr_fall_in(wr_hit(cmd_in, `SEA_SEL_CAL_FALL)),
		.wdata_in(cmd_in.data),
		.event_out(cal_event),
		.enable_out(cal_enable),
		.rise_out(cal_rise),
		.fall_out(cal_fall),
		.summary_out(cal_summary_out)
	);

	// Read data select, full sixteen bits
	assign nxt_rdata =
		(cmd_in.sel == `SEA_SEL_OP_COND) ? op_cond :
		(cmd_in.sel == `SEA_SEL_OP_EVENT) ? op_event :
		(cmd_in.sel == `SEA_SEL_OP_ENABLE) ? op_enable :
		(cmd_in.sel == `SEA_SEL_OP_RISE) ? op_rise :
		(cmd_in.sel == `SEA_SEL_OP_FALL) ? op_fall :
		(cmd_in.sel == `SEA_SEL_QU_COND) ? qu_cond :
		(cmd_in.sel == `SEA_SEL_QU_EVENT) ? qu_event :
		(cmd_in.sel == `SEA_SEL_QU_ENABLE) ? qu_enable :
		(cmd_in.sel == `SEA_SEL_QU_RISE) ? qu_rise :
		(cmd_in.sel == `SEA_SEL_QU_FALL) ? qu_fall :
		(cmd_in.sel == `SEA_SEL_DEV_ENABLE) ? dev_enable :
		(cmd_in.sel == `SEA_SEL_CAL_ENABLE) ? cal_enable :
		(cmd_in.sel == `SEA_SEL_DEV_RISE) ? dev_rise :
		(cmd_in.sel == `SEA_SEL_DEV_FALL) ? dev_fall :
		(cmd_in.sel == `SEA_SEL_CAL_RISE) ? cal_rise : cal_fall;

	// Registered read answer
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			rdata_ff <= `SEA_ALL_ZERO;
			rvalid_ff <= 1'b0;
		end else begin
			rvalid_ff <= cmd_in.rd;
			if (cmd_in.rd) rdata_ff <= nxt_rdata;
		end
	end
	assign rdata_out = rdata_ff;
	assign rvalid_out = rvalid_ff;

	// Operation event read returns old value, keeps only same-cycle edges
	sequence s_op_event_read;
		cmd_in.rd && (cmd_in.sel == `SEA_SEL_OP_EVENT);
	endsequence
	AST_OP_READ_CLEAR: assert property (@(posedge clock_in) disable iff (rst_in)
		s_op_event_read |=> (rdata_out == $past(op_event))
		&& (op_event == $past(u_op.rise_hit | u_op.fall_hit)))
		else $error("operation read clear wrong");
	// Questionable event read returns old value, keeps only same-cycle edges
	sequence s_qu_event_read;
		cmd_in.rd && (cmd_in.sel == `SEA_SEL_QU_EVENT);
	endsequence
	AST_QU_READ_CLEAR: assert property (@(posedge clock_in) disable iff (rst_in)
		s_qu_event_read |=> (rdata_out == $past(qu_event))
		&& (qu_event == $past(u_qu.rise_hit | u_qu.fall_hit)))
		else $error("questionable read wrong");
	// Preset loads masks and filters
	AST_PRESET: assert property (@(posedge clock_in) disable iff (rst_in)
		preset_in |=> (op_enable == 16'h0000) && (qu_enable == 16'h0000)
		&& (dev_enable == 16'hffff) && (cal_enable == 16'hffff)
		&& (qu_rise == 16'hffff) && (op_fall == 16'h0000))
		else $error("preset values wrong");
	// Preset loads the remaining filters of every group
	AST_PRESET_FILTERS: assert property (@(posedge clock_in) disable iff (rst_in)
		preset_in |=> (op_rise == 16'hffff) && (dev_rise == 16'hffff)
		&& (cal_rise == 16'hffff) && (qu_fall == 16'h0000)
		&& (dev_fall == 16'h0000) && (cal_fall == 16'h0000))
		else $error("preset filters wrong");
	// Summaries follow masked events
	AST_SUMMARY: assert property (@(posedge clock_in) disable iff (rst_in)
		(qu_summary_out == |(qu_event & qu_enable))
		&& (op_summary_out == |(op_event & op_enable)))
		else $error("summary mismatch");
	// Fully enabled device and calibration groups report any event
	AST_DEV_CAL_SUMMARY: assert property (@(posedge clock_in) disable iff (rst_in)
		((dev_enable == 16'hffff) && (dev_event != 16'h0000) |-> dev_summary_out)
		and ((cal_enable == 16'hffff) && (cal_event != 16'h0000) |-> cal_summary_out))
		else $error("device or calibration summary wrong");
	// Unused questionable condition bits and unused operation event bits stay zero
	AST_UNUSED_ZERO: assert property (@(posedge clock_in) disable iff (rst_in)
		((qu_cond & 16'hfef7) == 16'h0000) && ((op_event & 16'hf0c8) == 16'h0000))
		else $error("unused bit active");
	// Questionable bits follow the stable pins
	AST_VOLT_BIT: assert property (@(posedge clock_in) disable iff (rst_in)
		(qu_cond[`SEA_QU_VOLT_BIT] == stable_ff[9]) && (qu_cond[`SEA_QU_ZERO_BIT] == stable_ff[10]))
		else $error("questionable condition wrong");
	// Pin change reaches condition within four cycles
	sequence s_volt_held;
		$rose(sync1_ff[9]) ##1 sync1_ff[9] [*3];
	endsequence
	AST_VOLT_LATENCY: assert property (@(posedge clock_in) disable iff (rst_in)
		s_volt_held |-> qu_cond[`SEA_QU_VOLT_BIT])
		else $error("voltage bit late");
	// Rising edge with filter set latches the event
	AST_RISE_EVENT: assert property (@(posedge clock_in) disable iff (rst_in)
		($rose(qu_cond[`SEA_QU_VOLT_BIT]) && qu_rise[`SEA_QU_VOLT_BIT])
		|=> qu_event[`SEA_QU_VOLT_BIT])
		else $error("rising edge lost");
	// Falling edge with filter set latches the event
	sequence s_qu_volt_fall;
		$fell(qu_cond[`SEA_QU_VOLT_BIT]) && qu_fall[`SEA_QU_VOLT_BIT];
	endsequence
	AST_FALL_EVENT: assert property (@(posedge clock_in) disable iff (rst_in)
		s_qu_volt_fall |=> qu_event[`SEA_QU_VOLT_BIT])
		else $error("falling edge lost");
	// Rising measuring edge through the operation filter
	sequence s_op_meas_rise;
		$rose(op_cond[`SEA_OP_MEAS_BIT]) && op_rise[`SEA_OP_MEAS_BIT];
	endsequence
	AST_OP_RISE_EVENT: assert property (@(posedge clock_in) disable iff (rst_in)
		s_op_meas_rise |=> op_event[`SEA_OP_MEAS_BIT])
		else $error("operation rising edge lost");
	// Every read answers one cycle later, and only a read does
	AST_READ_ANSWER: assert property (@(posedge clock_in) disable iff (rst_in)
		(cmd_in.rd |=> rvalid_out) and (!cmd_in.rd |=> !rvalid_out))
		else $error("read answer timing wrong");
endmodule : sea_status_top
`default_nettype wire

// ### tb_status_event_aggregator.sv
// Testbench for the status event aggregator top
// Assumes sea_map.svh, sea_pkg and the host model are compiled first
`timescale 1ns/1ps
`default_nettype none
`include "sea_map.svh"
module tb_status_event_aggregator;
	import sea_pkg::*;
	logic clock_in, rst_in, preset_in, volt_invalid_in, zero_needed_in;
	logic rvalid_out, op_summary_out, qu_summary_out, dev_summary_out, cal_summary_out;
	logic [15:0] dev_cond_in, cal_cond_in, rdata_out, got;
	sea_cmd_t cmd_in;
	sea_op_state_t op_state_in;
	int bad_count, cmp_count, cyc, i;
	logic [3:0] sels [12] = '{4'h2, 4'h3, 4'h4, 4'h7, 4'h8, 4'h9, 4'ha, 4'hb, 4'hc, 4'hd, 4'he, 4'hf};
	sea_status_top dut (.clock_in(clock_in), .rst_in(rst_in), .cmd_in(cmd_in),
		.preset_in(preset_in), .rdata_out(rdata_out), .rvalid_out(rvalid_out),
		.op_state_in(op_state_in), .volt_invalid_in(volt_invalid_in),
		.zero_needed_in(zero_needed_in), .dev_cond_in(dev_cond_in), .cal_cond_in(cal_cond_in),
		.op_summary_out(op_summary_out), .qu_summary_out(qu_summary_out),
		.dev_summary_out(dev_summary_out), .cal_summary_out(cal_summary_out));
	sea_host_model host (.clock_in(clock_in), .rvalid_in(rvalid_out), .rdata_in(rdata_out),
		.cmd_out(cmd_in));
	// Clock, 20 ns period
	initial begin
		clock_in = 1'b0;
		forever #10 clock_in = ~clock_in;
	end
	// Cycle ceiling against hangs
	always @(posedge clock_in) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			bad_count = bad_count + 1;
			summarize();
		end
	end
	// Expected filter and mask values after reset or preset
	function automatic logic [15:0] exp_init(input logic [3:0] sel);
		case (sel)
			`SEA_SEL_OP_RISE, `SEA_SEL_QU_RISE, `SEA_SEL_DEV_RISE, `SEA_SEL_CAL_RISE: return `SEA_ALL_ONE;
			`SEA_SEL_DEV_ENABLE, `SEA_SEL_CAL_ENABLE: return `SEA_ALL_ONE;
			default: return `SEA_ALL_ZERO;
		endcase
	endfunction : exp_init
	// Word compare
	task chk16(input logic [15:0] g, input logic [15:0] e, input string what);
		cmp_count = cmp_count + 1;
		if (g !== e) begin
			bad_count = bad_count + 1;
			$display("[ERR] %0t %s got %h expected %h", $time, what, g, e);
		end
	endtask : chk16
	// Flag compare
	task chk1(input logic g, input logic e, input string what);
		cmp_count = cmp_count + 1;
		if (g !== e) begin
			bad_count = bad_count + 1;
			$display("[ERR] %0t %s got %b expected %b", $time, what, g, e);
		end
	endtask : chk1
	// Wait past the pin synchroniser
	task settle();
		repeat (6) @(negedge clock_in);
	endtask : settle
	// Counts and verdict
	task summarize();
		$display("comparisons %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : summarize
	// Main sequence
	initial begin
		cyc = 0;
		bad_count = 0;
		cmp_count = 0;
		rst_in = 1'b1;
		preset_in = 1'b0;
		volt_invalid_in = 1'b0;
		zero_needed_in = 1'b0;
		op_state_in = '0;
		dev_cond_in = '0;
		cal_cond_in = '0;
		repeat (4) @(posedge clock_in);
		@(negedge clock_in);
		rst_in = 1'b0;
		// Reset values of masks and filters
		for (i = 0; i < 12; i++) begin
			host.read_reg(sels[i], got);
			chk16(got, exp_init(sels[i]), "reset value");
		end
		// Full width write and readback
		for (i = 0; i < 12; i++) begin
			host.write_reg(sels[i], {sels[i], ~sels[i], ~sels[i], sels[i]});
			host.read_reg(sels[i], got);
			chk16(got, {sels[i], ~sels[i], ~sels[i], sels[i]}, "readback");
		end
		// Preset restores defaults
		@(negedge clock_in);
		preset_in = 1'b1;
		@(negedge clock_in);
		preset_in = 1'b0;
		for (i = 0; i < 12; i++) begin
			host.read_reg(sels[i], got);
			chk16(got, exp_init(sels[i]), "preset value");
		end
		// Device and calibration summaries follow all-one enables
		dev_cond_in = 16'h0002;
		cal_cond_in = 16'h0004;
		settle();
		chk1(dev_summary_out, 1'b1, "dev summary");
		chk1(cal_summary_out, 1'b1, "cal summary");
		// Questionable condition follows live pins
		volt_invalid_in = 1'b1;
		settle();
		host.read_reg(`SEA_SEL_QU_COND, got);
		chk16(got, 16'h0008, "qu cond volt");
		zero_needed_in = 1'b1;
		settle();
		host.read_reg(`SEA_SEL_QU_COND, got);
		chk16(got, 16'h0108, "qu cond zero");
		volt_invalid_in = 1'b0;
		settle();
		host.read_reg(`SEA_SEL_QU_COND, got);
		chk16(got, 16'h0100, "qu cond live");
		zero_needed_in = 1'b0;
		settle();
		host.read_reg(`SEA_SEL_QU_COND, got);
		chk16(got, 16'h0000, "qu cond idle");
		host.read_reg(`SEA_SEL_QU_EVENT, got);
		chk16(got, 16'h0108, "qu rising events");
		host.read_reg(`SEA_SEL_QU_EVENT, got);
		chk16(got, 16'h0000, "qu event cleared");
		// Questionable summary through the enable mask
		host.write_reg(`SEA_SEL_QU_ENABLE, 16'h0008);
		chk1(qu_summary_out, 1'b0, "qu summary idle");
		volt_invalid_in = 1'b1;
		settle();
		chk1(qu_summary_out, 1'b1, "qu summary set");
		host.read_reg(`SEA_SEL_QU_EVENT, got);
		chk16(got, 16'h0008, "qu event volt");
		chk1(qu_summary_out, 1'b0, "qu summary after read");
		// Falling filter only
		host.write_reg(`SEA_SEL_QU_RISE, 16'h0000);
		host.write_reg(`SEA_SEL_QU_FALL, 16'h0008);
		volt_invalid_in = 1'b0;
		settle();
		host.read_reg(`SEA_SEL_QU_EVENT, got);
		chk16(got, 16'h0008, "qu falling event");
		// Operation layout, condition write ignored
		op_state_in = '1;
		settle();
		host.write_reg(`SEA_SEL_OP_COND, 16'h0000);
		host.read_reg(`SEA_SEL_OP_COND, got);
		chk16(got, `SEA_OP_USED_MASK, "op cond layout");
		host.read_reg(`SEA_SEL_OP_EVENT, got);
		chk16(got, `SEA_OP_USED_MASK, "op rising events");
		host.write_reg(`SEA_SEL_OP_RISE, 16'h0000);
		host.write_reg(`SEA_SEL_OP_FALL, 16'h0004);
		host.write_reg(`SEA_SEL_OP_ENABLE, 16'h0004);
		chk1(op_summary_out, 1'b0, "op summary idle");
		op_state_in = '0;
		settle();
		chk1(op_summary_out, 1'b1, "op summary set");
		host.read_reg(`SEA_SEL_OP_EVENT, got);
		chk16(got, 16'h0004, "op falling event");
		chk1(op_summary_out, 1'b0, "op summary after read");
		// Edge arriving during continuous event reads
		host.write_reg(`SEA_SEL_OP_RISE, 16'h0010);
		@(negedge clock_in);
		op_state_in.measuring = 1'b1;
		host.read_burst(`SEA_SEL_OP_EVENT, 12, got);
		chk16(got, 16'h0010, "edge during read");
		host.read_reg(`SEA_SEL_OP_EVENT, got);
		chk16(got, 16'h0000, "op event cleared");
		summarize();
	end
endmodule : tb_status_event_aggregator
`default_nettype wire
